/* bench/fabric_port.sv */
// Purpose: user fabric model that drives one memory port
// Assumes: common clock; requests launched just after the rising edge
// Notes: released lines flip so a stale value cannot pass unseen
`timescale 1ns/1ps
module fabric_port (
  input wire logic clk, // common clock
  output logic en, // port enable
  output logic [3:0] we, // lane strobes
  output logic [9:0] addr, // word address
  output logic [31:0] wd, // write data
  output logic [3:0] wp, // write parity
  output logic pre, // output preset
  output logic gate, // output register enable
  output logic cl, // chain in, latch path
  output logic cr, // chain in, register path
  output logic csel // chain select
);
  initial begin
    {en, we, addr, wd, wp, pre, gate, cl, cr, csel} = 56'h8;
  end
  // one request per call; the bench never aims both ports' writes
  // at one word with different data
  task automatic access(input logic [9:0] a, input logic [35:0] d,
                        input logic [3:0] w);
    @(posedge clk);
    en <= 1'b1;
    we <= w;
    addr <= a;
    {wp, wd} <= d;
  endtask
  // strobes flip too: a port that ignores en would write garbage
  task automatic idle();
    @(posedge clk);
    en <= 1'b0;
    we <= ~we;
    addr <= ~addr;
    {wp, wd} <= ~{wp, wd};
  endtask
  task automatic ctl(input logic p, g, s, l, r);
    @(posedge clk);
    {pre, gate, csel, cl, cr} <= {p, g, s, l, r};
  endtask
endmodule

/* bench/true_dual_port_block_memory_tb_top.sv */
// Purpose: self-checking bench for the dual-port memory
// Assumes: port A transparent latch, port B read-first with register
// Notes: hold mode is not instanced here
`timescale 1ns/1ps
module true_dual_port_block_memory_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  int fails = 0;
  int tests_run = 0;
  logic en_a, pre_a, g_a, cl_a, cr_a, s_a, en_b, pre_b, g_b, cl_b, cr_b, s_b;
  logic [3:0] we_a, wp_a, we_b, wp_b, dpa, dpb;
  logic [9:0] ad_a, ad_b;
  logic [31:0] wd_a, wd_b, doa, dob;
  logic col_a, cor_a, col_b, cor_b;
  logic [35:0] qa, qb, m;
  assign qa = {dpa, doa};
  assign qb = {dpb, dob};
  always #4 clk = ~clk;
  fabric_port pa (.clk(clk), .en(en_a), .we(we_a), .addr(ad_a), .wd(wd_a),
    .wp(wp_a), .pre(pre_a), .gate(g_a), .cl(cl_a), .cr(cr_a), .csel(s_a));
  fabric_port pb (.clk(clk), .en(en_b), .we(we_b), .addr(ad_b), .wd(wd_b),
    .wp(wp_b), .pre(pre_b), .gate(g_b), .cl(cl_b), .cr(cr_b), .csel(s_b));
  tdp_mem #(.MODE_B(tdp_mem_pkg::WM_READ_FIRST), .PIPE_B(1'b1)) uut (
    .clk(clk), .srst(srst), .en_a(en_a), .we_a(we_a), .addr_a(ad_a),
    .write_data_in_a(wd_a), .write_parity_in_a(wp_a),
    .sync_output_preset_a(pre_a), .output_pipe_clock_gate_a(g_a),
    .chain_in_latched_a(cl_a), .chain_in_registered_a(cr_a),
    .chain_sel_a(s_a), .read_data_out_a(doa), .read_parity_out_a(dpa),
    .chain_out_latched_a(col_a), .chain_out_registered_a(cor_a),
    .en_b(en_b), .we_b(we_b), .addr_b(ad_b),
    .write_data_in_b(wd_b), .write_parity_in_b(wp_b),
    .sync_output_preset_b(pre_b), .output_pipe_clock_gate_b(g_b),
    .chain_in_latched_b(cl_b), .chain_in_registered_b(cr_b),
    .chain_sel_b(s_b), .read_data_out_b(dob), .read_parity_out_b(dpb),
    .chain_out_latched_b(col_b), .chain_out_registered_b(cor_b));
  task automatic check(input logic [35:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic op_a(input logic [9:0] a, input logic [35:0] d,
                      input logic [3:0] w);
    pa.access(a, d, w);
    pa.idle();
    #1;
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, n,
                                        input logic [3:0] w);
    logic [35:0] r;
    r = o;
    for (int k = 0; k < 4; k++) if (w[k]) begin
      r[8*k+:8] = n[8*k+:8];
      r[32+k] = n[32+k];
    end
    return r;
  endfunction
  // tests need about fifty cycles; eighty times that marks a hang
  initial begin
    #(8 * 4000);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      op_a(i ? 10'h3FF : 10'h000, 36'hA5C3E1F07 + i, 4'hF);
      check(qa, 36'hA5C3E1F07 + i);
    end
    op_a(10'h000, 36'h0, 4'h0);
    check(qa, 36'hA5C3E1F07);
    pb.access(10'h3FF, 36'h0, 4'h0);
    pb.idle();
    #1;
    check(qb, 36'h0);
    @(posedge clk);
    #1;
    check(qb, 36'hA5C3E1F08);
    $display("test basic done");
    op_a(10'h005, 36'h912345678, 4'hF);
    op_a(10'h005, 36'h5F0E1D2C3, 4'h5);
    m = merge(36'h912345678, 36'h5F0E1D2C3, 4'h5);
    check(qa, m);
    repeat (4) pa.idle();
    #1;
    check(qa, m);
    op_a(10'h005, 36'h0, 4'h0);
    check(qa, m);
    $display("test lanes done");
    fork
      pa.access(10'h005, 36'h0, 4'h0);
      pb.access(10'h005, 36'h3DEADBEEF, 4'hF);
    join
    fork
      pa.idle();
      pb.idle();
    join
    #1;
    check(qa, m);
    @(posedge clk);
    #1;
    check(qb, m);
    op_a(10'h005, 36'h0, 4'h0);
    check(qa, 36'h3DEADBEEF);
    $display("test collision done");
    pb.ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    pb.access(10'h000, 36'h0, 4'h0);
    pb.idle();
    @(posedge clk);
    #1;
    check(qb, m);
    pb.ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    check(qb, 36'hA5C3E1F07);
    fork
      pa.access(10'h000, 36'h0, 4'h0);
      pa.ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      pb.ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    join
    fork
      pa.idle();
      pa.ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      pb.ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    join
    #1;
    check(qa, 36'h0);
    check(qb, 36'h0);
    @(posedge clk);
    #1;
    check(qb, 36'hA5C3E1F07);
    check({34'h0, col_b, cor_b}, 36'h3);
    $display("test register done");
    for (int i = 1; i < 3; i++) begin
      pa.ctl(1'b0, 1'b1, 1'b1, i[1], i[0]);
      @(posedge clk);
      #1;
      check({34'h0, col_a, cor_a}, 36'(i));
    end
    pa.ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    op_a(10'h3FF, 36'h0, 4'h0);
    check({35'h0, col_a}, 36'h0);
    $display("test chain done");
    wrap_up();
  end
endmodule

/* logic/tdp_mem.sv */
// Purpose: true dual-port memory, 36 Kb as 1K x 36 words
// Assumes: both ports on clk (common clock), inputs synchronous
// Notes: no arbitration; same-word clashes follow the mode table;
//   array content has no reset, so the lane-write, idle-array and port B read checks skip unwritten words;
//   register-mode checks watch the latch inside the output stage, except the latency check on dout_b
//
// Behaviour
// - one shared 36 Kb array, two equal independent ports A and B
// - each port has own address, data, enable, strobes; all synchronous
// - inactive enable: no write, output keeps previous value; here the output register still loads and presets on its own enable
// - latch mode read takes one edge, word loaded into latch
// - output register adds one cycle of read latency
// - write completes on one edge at the captured address
// - static per-port write mode, transparent by default
// - transparent mode shows written data on output
// - read-first mode shows old stored word during write
// - hold mode leaves output unchanged during write
// - no arbitration; clashing writes give uncertain data, no damage
// - read-first writer: both outputs show old word, write succeeds
// - transparent or hold writer: reader output invalid
// - output register has own enable, holds independently
// - read and write widths independently chosen per port; here both ports are fixed at 36 bits for read and write
// - mixed widths transparent: new enabled lanes, old others
// - sync preset forces output to initial value in both modes
// - cascade in and out pins, latched and registered
// - parity bits stored and read as ordinary bits
// - register preset needs clock enable; latch preset needs enable
// - each strobe writes one byte plus its parity bit
`timescale 1ns/1ps
module tdp_mem #(
  parameter tdp_mem_pkg::write_mode_t MODE_A =
    tdp_mem_pkg::WM_TRANSPARENT,
  parameter tdp_mem_pkg::write_mode_t MODE_B =
    tdp_mem_pkg::WM_TRANSPARENT,
  parameter bit PIPE_A = 1'b0, // output register on port A
  parameter bit PIPE_B = 1'b0 // output register on port B
) (
  input wire logic clk, // common port clock
  input wire logic srst, // synchronous reset
  input wire logic en_a, // port A enable
  input wire logic [tdp_mem_pkg::LANES-1:0] we_a, // port A lane strobes
  input wire logic [tdp_mem_pkg::ADDR_W-1:0] addr_a, // port A address
  input wire logic [tdp_mem_pkg::DATA_W-1:0] write_data_in_a, // A data
  input wire logic [tdp_mem_pkg::PAR_W-1:0] write_parity_in_a, // A par
  input wire logic sync_output_preset_a, // A output preset
  input wire logic output_pipe_clock_gate_a, // A register enable
  input wire logic chain_in_latched_a, // A chain in, latch
  input wire logic chain_in_registered_a, // A chain in, register
  input wire logic chain_sel_a, // A uses chain input
  output logic [tdp_mem_pkg::DATA_W-1:0] read_data_out_a, // A data out
  output logic [tdp_mem_pkg::PAR_W-1:0] read_parity_out_a, // A parity
  output logic chain_out_latched_a, // A chain out, latch
  output logic chain_out_registered_a, // A chain out, register
  input wire logic en_b, // port B enable
  input wire logic [tdp_mem_pkg::LANES-1:0] we_b, // port B lane strobes
  input wire logic [tdp_mem_pkg::ADDR_W-1:0] addr_b, // port B address
  input wire logic [tdp_mem_pkg::DATA_W-1:0] write_data_in_b, // B data
  input wire logic [tdp_mem_pkg::PAR_W-1:0] write_parity_in_b, // B par
  input wire logic sync_output_preset_b, // B output preset
  input wire logic output_pipe_clock_gate_b, // B register enable
  input wire logic chain_in_latched_b, // B chain in, latch
  input wire logic chain_in_registered_b, // B chain in, register
  input wire logic chain_sel_b, // B uses chain input
  output logic [tdp_mem_pkg::DATA_W-1:0] read_data_out_b, // B data out
  output logic [tdp_mem_pkg::PAR_W-1:0] read_parity_out_b, // B parity
  output logic chain_out_latched_b, // B chain out, latch
  output logic chain_out_registered_b // B chain out, register
);
  localparam int W = tdp_mem_pkg::WORD_W;
  localparam int N = tdp_mem_pkg::LANES;
  localparam int AW = tdp_mem_pkg::ADDR_W;

  // ****************************************
  // storage and helpers
  // ****************************************
  logic [W-1:0] mem_ff [tdp_mem_pkg::DEPTH];
  logic [W-1:0] wword_a, wword_b, old_a, old_b;
  logic [W-1:0] lat_d_a, lat_d_b;
  logic load_a, load_b;
  logic [W-1:0] dout_a, dout_b;

  // byte lane k at bit 8*k, its parity bit at 32+k: parity packed above the data
  function automatic logic [W-1:0] pack_word(
      input logic [tdp_mem_pkg::DATA_W-1:0] d,
      input logic [tdp_mem_pkg::PAR_W-1:0] p);
    pack_word = {p, d};
  endfunction

  // lane merge: enabled lanes from nw, others from ow
  function automatic logic [W-1:0] merge_lanes(
      input logic [W-1:0] nw, input logic [W-1:0] ow,
      input logic [N-1:0] we);
    logic [W-1:0] r;
    r = ow;
    for (int k = 0; k < N; k++) begin
      if (we[k]) begin
        r[k*tdp_mem_pkg::LANE_W +: tdp_mem_pkg::LANE_W] =
          nw[k*tdp_mem_pkg::LANE_W +: tdp_mem_pkg::LANE_W];
        r[tdp_mem_pkg::DATA_W+k] = nw[tdp_mem_pkg::DATA_W+k];
      end
    end
    merge_lanes = r;
  endfunction

  // latch next value and load decision for one port
  function automatic logic [W:0] latch_next(
      input tdp_mem_pkg::write_mode_t md, input logic [N-1:0] we,
      input logic [W-1:0] nw, input logic [W-1:0] ow);
    logic [W:0] r;
    r = {1'b1, ow};
    if (we != '0) begin
      unique case (md)
        tdp_mem_pkg::WM_TRANSPARENT:
          r = {1'b1, merge_lanes(nw, ow, we)};
        tdp_mem_pkg::WM_READ_FIRST: r = {1'b1, ow};
        tdp_mem_pkg::WM_HOLD: r = {1'b0, ow};
      endcase
    end
    latch_next = r;
  endfunction

  // a port writes only when enabled with at least one lane strobe
  function automatic logic is_write(input logic en,
      input logic [N-1:0] we);
    is_write = en && (we != '0);
  endfunction

  assign wword_a = pack_word(write_data_in_a, write_parity_in_a);
  assign wword_b = pack_word(write_data_in_b, write_parity_in_b);
  assign old_a = mem_ff[addr_a];
  assign old_b = mem_ff[addr_b];
  assign {load_a, lat_d_a} = latch_next(MODE_A, we_a, wword_a, old_a);
  assign {load_b, lat_d_b} = latch_next(MODE_B, we_b, wword_b, old_b);

  // ****************************************
  // access decode
  // ****************************************
  logic wr_a, wr_b, same_word;
  assign wr_a = is_write(en_a, we_a);
  assign wr_b = is_write(en_b, we_b);
  assign same_word = addr_a == addr_b;

  // ****************************************
  // written-word tracker
  // ****************************************
  // one flop per word, kept out of the data path; only the checks
  // read it, so unwritten words never trip the lane-write, idle-array or port B read compares
  logic [tdp_mem_pkg::DEPTH-1:0] filled_ff;
  for (genvar i = 0; i < tdp_mem_pkg::DEPTH; i++) begin : g_fill
    always_ff @(posedge clk) begin
      if (srst) begin
        filled_ff[i] <= 1'b0;
      end else if ((wr_a && addr_a == AW'(i))
          || (wr_b && addr_b == AW'(i))) begin
        filled_ff[i] <= 1'b1;
      end
    end
  end

  // ****************************************
  // array writes
  // ****************************************
  // no arbitration: on a same-word clash B's lanes land last; the
  // user keeps such clashes to identical data
  always_ff @(posedge clk) begin
    if (wr_a) begin
      mem_ff[addr_a] <= merge_lanes(wword_a, old_a, we_a);
    end
    if (wr_b) begin
      mem_ff[addr_b] <= merge_lanes(wword_b, old_b, we_b);
    end
  end

  // ****************************************
  // output stages
  // ****************************************
  // reader sees the pre-edge word on a same-word clash: right for a
  // read-first writer, merely one possible value otherwise
  tdp_port_out u_out_a (
    .clk(clk),
    .srst(srst),
    .use_pipe(PIPE_A),
    .en(en_a),
    .load_latch(load_a),
    .latch_d(lat_d_a),
    .preset(sync_output_preset_a),
    .pipe_ce(output_pipe_clock_gate_a),
    .chain_in_latched(chain_in_latched_a),
    .chain_in_registered(chain_in_registered_a),
    .chain_sel(chain_sel_a),
    .dout(dout_a),
    .chain_out_latched(chain_out_latched_a),
    .chain_out_registered(chain_out_registered_a)
  );
  tdp_port_out u_out_b (
    .clk(clk),
    .srst(srst),
    .use_pipe(PIPE_B),
    .en(en_b),
    .load_latch(load_b),
    .latch_d(lat_d_b),
    .preset(sync_output_preset_b),
    .pipe_ce(output_pipe_clock_gate_b),
    .chain_in_latched(chain_in_latched_b),
    .chain_in_registered(chain_in_registered_b),
    .chain_sel(chain_sel_b),
    .dout(dout_b),
    .chain_out_latched(chain_out_latched_b),
    .chain_out_registered(chain_out_registered_b)
  );
  assign {read_parity_out_a, read_data_out_a} = dout_a;
  assign {read_parity_out_b, read_data_out_b} = dout_b;

  // ****************************************
  // checks
  // ****************************************
  a_idle_hold: assert property (@(posedge clk) disable iff (srst)
    !en_a && !PIPE_A |=> $stable(dout_a))
    else $error("port A output moved while disabled");
  a_latch_read: assert property (@(posedge clk) disable iff (srst)
    en_a && we_a == '0 && !sync_output_preset_a && !PIPE_A
    |=> dout_a == $past(old_a))
    else $error("port A read data wrong");
  a_write_store: assert property (@(posedge clk) disable iff (srst)
    en_a && we_a == '1 && !(en_b && we_b != '0 && addr_b == addr_a)
    |=> mem_ff[$past(addr_a)] == $past(wword_a))
    else $error("port A write not stored");
  a_trans_show: assert property (@(posedge clk) disable iff (srst)
    en_a && we_a != '0 && MODE_A == tdp_mem_pkg::WM_TRANSPARENT
    && !sync_output_preset_a && !PIPE_A
    |=> dout_a == merge_lanes($past(wword_a), $past(old_a),
    $past(we_a)))
    else $error("port A transparent output wrong");
  a_read_first: assert property (@(posedge clk) disable iff (srst)
    wr_b && MODE_B == tdp_mem_pkg::WM_READ_FIRST
    && !(sync_output_preset_b && !PIPE_B)
    |=> u_out_b.latch_ff == $past(old_b))
    else $error("port B read-first output wrong");
  a_hold_mode: assert property (@(posedge clk) disable iff (srst)
    en_a && we_a != '0 && MODE_A == tdp_mem_pkg::WM_HOLD
    && !sync_output_preset_a && !PIPE_A |=> $stable(dout_a))
    else $error("port A hold output moved");
  a_latch_preset: assert property (@(posedge clk) disable iff (srst)
    en_b && sync_output_preset_b && !PIPE_B
    |=> dout_b == {tdp_mem_pkg::PAR_INIT, tdp_mem_pkg::DATA_INIT})
    else $error("port B latch preset failed");
  a_no_write_off: assert property (@(posedge clk) disable iff (srst)
    !en_a && !en_b && filled_ff[addr_a]
    |=> mem_ff[$past(addr_a)] == $past(old_a))
    else $error("array changed while ports disabled");
  a_latch_preset_a: assert property (@(posedge clk) disable iff (srst)
    en_a && sync_output_preset_a && !PIPE_A
    |=> dout_a == {tdp_mem_pkg::PAR_INIT, tdp_mem_pkg::DATA_INIT})
    else $error("port A latch preset failed");
  a_lane_write: assert property (@(posedge clk) disable iff (srst)
    wr_a && filled_ff[addr_a] && !(wr_b && same_word)
    |=> mem_ff[$past(addr_a)] == merge_lanes($past(wword_a),
    $past(old_a), $past(we_a)))
    else $error("port A lane write wrong");
  a_read_first_a: assert property (@(posedge clk) disable iff (srst)
    wr_a && MODE_A == tdp_mem_pkg::WM_READ_FIRST
    && !(sync_output_preset_a && !PIPE_A)
    |=> u_out_a.latch_ff == $past(old_a))
    else $error("port A read-first output wrong");
  a_chain_pipe_a: assert property (@(posedge clk) disable iff (srst)
    chain_sel_a && output_pipe_clock_gate_a && !sync_output_preset_a
    |=> !chain_sel_a
    || chain_out_registered_a == $past(chain_in_registered_a))
    else $error("port A registered chain path wrong");

  // ****************************************
  // checks, port B latch, register and array
  // ****************************************
  // port B may run in register mode, so its output checks watch its latch, except a_pipe_late_b on dout_b
  a_idle_hold_b: assert property (@(posedge clk) disable iff (srst)
    !en_b |=> $stable(u_out_b.latch_ff))
    else $error("port B latch moved while disabled");
  a_latch_read_b: assert property (@(posedge clk) disable iff (srst)
    en_b && !wr_b && filled_ff[addr_b]
    && !(sync_output_preset_b && !PIPE_B)
    |=> u_out_b.latch_ff == $past(old_b))
    else $error("port B read data wrong");
  a_write_store_b: assert property (@(posedge clk) disable iff (srst)
    en_b && we_b == '1 |=> mem_ff[$past(addr_b)] == $past(wword_b))
    else $error("port B write not stored");
  a_trans_show_b: assert property (@(posedge clk) disable iff (srst)
    wr_b && MODE_B == tdp_mem_pkg::WM_TRANSPARENT
    && !(sync_output_preset_b && !PIPE_B)
    |=> u_out_b.latch_ff == merge_lanes($past(wword_b), $past(old_b),
    $past(we_b)))
    else $error("port B transparent output wrong");
  a_hold_mode_b: assert property (@(posedge clk) disable iff (srst)
    wr_b && MODE_B == tdp_mem_pkg::WM_HOLD
    && !(sync_output_preset_b && !PIPE_B)
    |=> $stable(u_out_b.latch_ff))
    else $error("port B hold output moved");
  a_no_write_off_b: assert property (@(posedge clk) disable iff (srst)
    !en_a && !en_b && filled_ff[addr_b]
    |=> mem_ff[$past(addr_b)] == $past(old_b))
    else $error("array changed under port B while idle");
  a_pipe_late_b: assert property (@(posedge clk) disable iff (srst)
    PIPE_B && en_b && !wr_b && filled_ff[addr_b] && !sync_output_preset_b
    ##1 output_pipe_clock_gate_b && !sync_output_preset_b
    |=> dout_b == $past(old_b, 2))
    else $error("port B register read latency wrong");

  // ****************************************
  // cross-port checks
  // ****************************************
  // only the read-first writer gives the reader a defined word
  a_clash_old: assert property (@(posedge clk) disable iff (srst)
    en_a && !wr_a && wr_b && same_word && !sync_output_preset_a
    && MODE_B == tdp_mem_pkg::WM_READ_FIRST
    |=> u_out_a.latch_ff == $past(old_a))
    else $error("port A clash read not old word");

  c_write_a: cover property (@(posedge clk) en_a && we_a != '0);
  c_pipe_read_b: cover property (@(posedge clk)
    PIPE_B && en_b && !wr_b ##1 output_pipe_clock_gate_b);
  c_read_b: cover property (@(posedge clk) en_b && we_b == '0);
  c_clash: cover property (@(posedge clk)
    en_a && en_b && we_a != '0 && addr_a == addr_b);
endmodule

/* logic/tdp_mem_pkg.sv */
// Purpose: shared constants for the true dual-port block memory
// Assumes: one system clock for both ports, sizes fixed
// Notes: write-mode codes are static configuration
package tdp_mem_pkg;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int WORD_W = 36;
  localparam int ADDR_W = 10;
  localparam int DEPTH = 1024;
  localparam logic [DATA_W-1:0] DATA_INIT = 32'h0000_0000;
  localparam logic [PAR_W-1:0] PAR_INIT = 4'h0;
  typedef enum logic [1:0] {
    WM_TRANSPARENT,
    WM_READ_FIRST,
    WM_HOLD
  } write_mode_t;
endpackage

/* logic/tdp_port_out.sv */
// Purpose: per-port output stage: latch, optional register, chain pins
// Assumes: inputs synchronous to clk
// Notes: register mode adds one cycle of latency
`timescale 1ns/1ps
module tdp_port_out (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic use_pipe, // output register selected
  input wire logic en, // port enable
  input wire logic load_latch, // latch takes latch_d
  input wire logic [tdp_mem_pkg::WORD_W-1:0] latch_d, // latch next value
  input wire logic preset, // sync output preset
  input wire logic pipe_ce, // output register clock enable
  input wire logic chain_in_latched, // chain input, latch path
  input wire logic chain_in_registered, // chain input, register path
  input wire logic chain_sel, // low half absent: take chain input
  output logic [tdp_mem_pkg::WORD_W-1:0] dout, // selected output
  output logic chain_out_latched, // chain output, latch path
  output logic chain_out_registered // chain output, register path
);
  logic [tdp_mem_pkg::WORD_W-1:0] latch_ff;
  logic [tdp_mem_pkg::WORD_W-1:0] pipe_ff;
  logic [tdp_mem_pkg::WORD_W-1:0] init_w;
  logic chain_pipe_ff;
  assign init_w = {tdp_mem_pkg::PAR_INIT, tdp_mem_pkg::DATA_INIT};

  // ****************************************
  // latch stage
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_ff <= init_w;
    end else if (en && preset && !use_pipe) begin
      latch_ff <= init_w;
    end else if (en && load_latch) begin
      latch_ff <= latch_d;
    end
  end

  // ****************************************
  // output register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      pipe_ff <= init_w;
      chain_pipe_ff <= 1'b0;
    end else if (pipe_ce) begin
      // preset leaves the latch alone in register mode
      pipe_ff <= preset ? init_w : latch_ff;
      chain_pipe_ff <= preset ? 1'b0 : chain_in_registered;
    end
  end

  assign dout = use_pipe ? pipe_ff : latch_ff;
  assign chain_out_latched = chain_sel ? chain_in_latched : latch_ff[0];
  assign chain_out_registered = chain_sel ? chain_pipe_ff : pipe_ff[0];

  a_pipe_hold: assert property (@(posedge clk) disable iff (srst)
    !pipe_ce |=> $stable(pipe_ff))
    else $error("output register moved without enable");
  a_preset_reg: assert property (@(posedge clk) disable iff (srst)
    pipe_ce && preset |=> pipe_ff == init_w)
    else $error("register preset failed");
  a_pipe_load: assert property (@(posedge clk) disable iff (srst)
    pipe_ce && !preset |=> pipe_ff == $past(latch_ff))
    else $error("register did not load latch");
  c_preset: cover property (@(posedge clk) pipe_ce && preset);
endmodule
